/* File: hdl/lcd_timing_cfg.svh */
/*
 constants of the display timing driver: clock rates, dividers, register map.
 assumes inclusion by the driver module and the bench.
*/
`ifndef LCD_TIMING_CFG_SVH
`define LCD_TIMING_CFG_SVH
`define LCD_SYS_HZ 50000000
`define LCD_CLK_SLOW_HZ 1970
`define LCD_CLK_FAST_HZ 2640
`define LCD_OSC_DIV 64
`define LCD_FRAME_DIV 24
`define LCD_OSC_CYC_SLOW (`LCD_SYS_HZ / (`LCD_CLK_SLOW_HZ * `LCD_OSC_DIV))
`define LCD_OSC_CYC_FAST (`LCD_SYS_HZ / (`LCD_CLK_FAST_HZ * `LCD_OSC_DIV))
`define LCD_SEG_COUNT 80
`define LCD_BP_COUNT 4
`define LCD_ADDR_CTRL 12'h000
`define LCD_ADDR_STATUS 12'h004
`define LCD_ADDR_RAM_LO 12'h100
`define LCD_ADDR_RAM_HI 12'h23C
`define LCD_CTRL_RESET 4'h0
`define LCD_STAT_SLOT_LSB 0
`define LCD_STAT_POL_BIT 2
`define LCD_STAT_CNT_LSB 3
`define LCD_STAT_FRAMES_LSB 8
`define LCD_RESP_OKAY 2'h0
`define LCD_RESP_SLVERR 2'h2
`endif

/* File: hdl/lcd_timing_pkg.sv */
/*
 types of the display timing driver.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package lcd_timing_pkg;
   typedef enum logic [1:0] {
      MODE_MUX4 = 2'h0,
      MODE_STATIC = 2'h1,
      MODE_MUX2 = 2'h2,
      MODE_MUX3 = 2'h3
   } drive_mode_t;
   typedef enum logic [1:0] {
      LVL_VSS = 2'h0,
      LVL_LO = 2'h1,
      LVL_HI = 2'h2,
      LVL_VLCD = 2'h3
   } level_t;
   typedef struct packed {
      logic disp_en;
      logic half_bias;
      drive_mode_t mode;
   } ctrl_t;
   typedef struct packed {
      logic [1:0] slot;
      logic pol;
      logic first;
   } phase_t;
endpackage
`default_nettype wire

/* File: hdl/lcd_timing_driver.sv */
/*
 display timing and drive sequencing core with an AXI4-Lite register slave.
 assumes a 50 MHz i_clock, pins synchronous to it, and one AXI4-Lite master.
*/
// Functional notes
// - internal oscillator divided by 64 gives the working clock.
// - oscillator select low: internal oscillator on, clock pin drives out.
// - oscillator select high: clock pin is input, used undivided.
// - one frame every 24 working-clock periods.
// - frame_rate_select high gives 1970 Hz clock, low 2640 Hz.
// - cascade_sync keeps frame timing aligned across drivers.
// - drive mode comes from the mode-setting command.
// - static mode: one backplane, two levels, segments fully on or off.
// - 1:2 mode: two slots, half bias or third bias.
// - 1:3 mode: three slots, third bias preferred.
// - 1:4 mode: four slots, third bias preferred.
// - half bias also allowed in 1:3 and 1:4 modes.
// - display register holds one slot of RAM, bit per segment.
// - 80 segment outputs from display register and current phase.
// - four backplanes follow mode; in 1:4 each has its own slot.
// - 1:3 mode: backplane 3 equals backplane 1.
// - 1:2 mode: backplane 2 equals 0, 3 equals 1.
// - static mode: all four backplanes identical.
// - reset selects 1:4 with third bias, display disabled.
// - RAM rows 0 to 3 feed slots of backplanes 0 to 3.
`include "lcd_timing_cfg.svh"
`default_nettype none
module lcd_timing_driver
   import lcd_timing_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [11:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [11:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_osc_select,
   input wire logic i_frame_rate_select,
   input wire logic i_clk_in,
   output logic o_clk_out,
   output logic o_clk_oe_n,
   input wire logic i_sync_in,
   output logic o_sync_out,
   output logic o_sync_oe_n,
   output var level_t o_backplane_out_0,
   output var level_t o_backplane_out_1,
   output var level_t o_backplane_out_2,
   output var level_t o_backplane_out_3,
   output var level_t [79:0] o_segment_outputs
);
   localparam logic [8:0] OSC_CYC_SLOW = 9'(`LCD_OSC_CYC_SLOW);
   localparam logic [8:0] OSC_CYC_FAST = 9'(`LCD_OSC_CYC_FAST);
   localparam logic [4:0] FRAME_LAST = 5'(`LCD_FRAME_DIV - 1);
   localparam logic [4:0] FRAME_HALF = 5'(`LCD_FRAME_DIV / 2);
   localparam int SEGS = `LCD_SEG_COUNT;
   localparam int BPS = `LCD_BP_COUNT;

   // ==========================================================
   // functions
   function automatic logic is_ram(input logic [11:0] a);
      return (a >= `LCD_ADDR_RAM_LO) && (a <= `LCD_ADDR_RAM_HI);
   endfunction

   function automatic logic [6:0] ram_idx(input logic [11:0] a);
      logic [11:0] off;
      off = a - `LCD_ADDR_RAM_LO;
      return off[8:2];
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return (a == `LCD_ADDR_CTRL) || (a == `LCD_ADDR_STATUS) || is_ram(a);
   endfunction

   function automatic phase_t decode_phase(input drive_mode_t m, input logic [4:0] c);
      phase_t p;
      logic [4:0] rem;
      p = '0;
      rem = 5'h00;
      case (m)
         MODE_STATIC: begin
            p.slot = 2'h0;
            p.pol = (c >= 5'd12);
            p.first = (c == 5'h00);
         end
         MODE_MUX2: begin
            p.slot = {1'b0, c >= 5'd12};
            p.pol = (c >= 5'd18) || ((c >= 5'd6) && (c < 5'd12));
            p.first = (c == 5'h00) || (c == 5'd12);
         end
         MODE_MUX3: begin
            p.slot = c[4:3];
            p.pol = c[2];
            p.first = (c[2:0] == 3'h0);
         end
         default: begin
            p.slot = (c < 5'd6) ? 2'h0 : (c < 5'd12) ? 2'h1 : (c < 5'd18) ? 2'h2 : 2'h3;
            rem = c - 5'({p.slot, 2'b00}) - 5'({p.slot, 1'b0});
            p.pol = (rem >= 5'd3);
            p.first = (rem == 5'h00);
         end
      endcase
      return p;
   endfunction

   function automatic logic bp_selected(input drive_mode_t m, input logic [1:0] i,
                                        input logic [1:0] s);
      case (m)
         MODE_STATIC: return 1'b1;
         MODE_MUX2: return i[0] == s[0];
         MODE_MUX3: return (i == 2'h3) ? (s == 2'h1) : (i == s);
         default: return i == s;
      endcase
   endfunction

   // half bias: both middle levels collapse onto one mid level
   function automatic level_t bp_level(input logic sel, input logic pol, input logic half);
      if (sel) begin
         return pol ? LVL_VSS : LVL_VLCD;
      end
      if (half) begin
         return LVL_LO;
      end
      return pol ? LVL_HI : LVL_LO;
   endfunction

   function automatic level_t seg_level(input logic on, input logic pol, input logic half,
                                        input logic stat);
      if (stat) begin
         return (on ^ pol) ? LVL_VSS : LVL_VLCD;
      end
      if (on) begin
         return pol ? LVL_VLCD : LVL_VSS;
      end
      if (half) begin
         return LVL_LO;
      end
      return pol ? LVL_LO : LVL_HI;
   endfunction

   // ==========================================================
   // working clock
   logic [8:0] osc_cnt_ff;
   logic [8:0] osc_limit;
   logic osc_tick;
   logic [5:0] div64_ff;
   logic clk_in_d_ff;
   logic tick;

   assign osc_limit = i_frame_rate_select ? OSC_CYC_SLOW - 9'h001 : OSC_CYC_FAST - 9'h001;
   assign osc_tick = (osc_cnt_ff == osc_limit);
   assign tick = i_osc_select ? (i_clk_in && !clk_in_d_ff) :
                 (osc_tick && (div64_ff == 6'h3F));

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         osc_cnt_ff <= 9'h000;
      end else if (osc_tick || (osc_cnt_ff > osc_limit)) begin
         osc_cnt_ff <= 9'h000;
      end else begin
         osc_cnt_ff <= osc_cnt_ff + 9'h001;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         div64_ff <= 6'h00;
      end else if (osc_tick) begin
         div64_ff <= div64_ff + 6'h01;
      end
   end

   // clock pin drives out only on the internal oscillator
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_in_d_ff <= 1'b0;
         o_clk_out <= 1'b0;
         o_clk_oe_n <= 1'b1;
      end else begin
         clk_in_d_ff <= i_clk_in;
         o_clk_out <= div64_ff[5];
         o_clk_oe_n <= i_osc_select;
      end
   end

   // ==========================================================
   // frame sequencer and cascade sync
   logic [4:0] frame_cnt_ff;
   logic [7:0] frames_ff;
   logic sync_in_d_ff;
   logic sync_fall;
   logic realign;

   assign sync_fall = sync_in_d_ff && !i_sync_in;
   // another driver started its frame first: follow it
   assign realign = sync_fall && (frame_cnt_ff != 5'h00);

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         frame_cnt_ff <= 5'h00;
      end else if (realign) begin
         frame_cnt_ff <= 5'h00;
      end else if (tick) begin
         frame_cnt_ff <= (frame_cnt_ff == FRAME_LAST) ? 5'h00 : frame_cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         frames_ff <= 8'h00;
      end else if (tick && !realign && (frame_cnt_ff == FRAME_LAST)) begin
         frames_ff <= frames_ff + 8'h01;
      end
   end

   // open drain: pulled low for the first half of each frame
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         sync_in_d_ff <= 1'b1;
         o_sync_out <= 1'b0;
         o_sync_oe_n <= 1'b1;
      end else begin
         sync_in_d_ff <= i_sync_in;
         o_sync_out <= 1'b0;
         o_sync_oe_n <= !(frame_cnt_ff < FRAME_HALF);
      end
   end

   // ==========================================================
   // registers and display RAM
   ctrl_t ctrl_ff;
   logic [3:0] ram_ff [SEGS];
   logic aw_got_ff;
   logic w_got_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic do_write;
   logic [31:0] rd_word;
   phase_t cur_phase;

   assign do_write = aw_got_ff && w_got_ff && !o_bvalid;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_awready <= 1'b0;
         aw_got_ff <= 1'b0;
         awaddr_ff <= 12'h000;
      end else if (i_awvalid && o_awready) begin
         o_awready <= 1'b0;
         aw_got_ff <= 1'b1;
         awaddr_ff <= i_awaddr;
      end else if (do_write) begin
         aw_got_ff <= 1'b0;
      end else if (!aw_got_ff && !o_bvalid) begin
         o_awready <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wready <= 1'b0;
         w_got_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (i_wvalid && o_wready) begin
         o_wready <= 1'b0;
         w_got_ff <= 1'b1;
         wdata_ff <= i_wdata;
         wstrb_ff <= i_wstrb;
      end else if (do_write) begin
         w_got_ff <= 1'b0;
      end else if (!w_got_ff && !o_bvalid) begin
         o_wready <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_bvalid <= 1'b0;
         o_bresp <= `LCD_RESP_OKAY;
      end else if (do_write) begin
         o_bvalid <= 1'b1;
         o_bresp <= mapped(awaddr_ff) ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // mode-set path: low byte lane carries the whole field
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_ff <= `LCD_CTRL_RESET;
      end else if (do_write && wstrb_ff[0] && (awaddr_ff == `LCD_ADDR_CTRL)) begin
         ctrl_ff <= wdata_ff[3:0];
      end
   end

   // no reset on the RAM: content is undefined until software fills it
   always_ff @(posedge i_clock) begin
      if (do_write && wstrb_ff[0] && is_ram(awaddr_ff)) begin
         ram_ff[ram_idx(awaddr_ff)] <= wdata_ff[3:0];
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (i_araddr == `LCD_ADDR_CTRL) begin
         rd_word[3:0] = ctrl_ff;
      end else if (i_araddr == `LCD_ADDR_STATUS) begin
         rd_word[`LCD_STAT_SLOT_LSB +: 2] = cur_phase.slot;
         rd_word[`LCD_STAT_POL_BIT] = cur_phase.pol;
         rd_word[`LCD_STAT_CNT_LSB +: 5] = frame_cnt_ff;
         rd_word[`LCD_STAT_FRAMES_LSB +: 8] = frames_ff;
      end else if (is_ram(i_araddr)) begin
         rd_word[3:0] = ram_ff[ram_idx(i_araddr)];
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= `LCD_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rdata <= rd_word;
         o_rresp <= mapped(i_araddr) ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end else if (!o_rvalid) begin
         o_arready <= 1'b1;
      end
   end

   // ==========================================================
   // display register and drive outputs
   phase_t phase_ff;
   logic moved_ff;
   logic [SEGS-1:0] row_bits;
   logic [SEGS-1:0] disp_reg_ff;
   level_t bp_ff [BPS];

   assign cur_phase = decode_phase(ctrl_ff.mode, frame_cnt_ff);

   always_comb begin
      for (int c = 0; c < SEGS; c++) begin
         row_bits[c] = ram_ff[c][cur_phase.slot];
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         phase_ff <= '0;
         moved_ff <= 1'b0;
      end else begin
         phase_ff <= cur_phase;
         moved_ff <= tick || realign;
      end
   end

   // loaded once per slot so a RAM write never tears a slot
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         disp_reg_ff <= '0;
      end else if (moved_ff && cur_phase.first) begin
         disp_reg_ff <= row_bits;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < BPS; i++) begin
            bp_ff[i] <= LVL_VLCD;
         end
      end else if (!ctrl_ff.disp_en) begin
         for (int i = 0; i < BPS; i++) begin
            bp_ff[i] <= LVL_VLCD;
         end
      end else begin
         for (int i = 0; i < BPS; i++) begin
            bp_ff[i] <= bp_level(bp_selected(ctrl_ff.mode, 2'(i), phase_ff.slot),
                                 phase_ff.pol, ctrl_ff.half_bias);
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int c = 0; c < SEGS; c++) begin
            o_segment_outputs[c] <= LVL_VLCD;
         end
      end else if (!ctrl_ff.disp_en) begin
         for (int c = 0; c < SEGS; c++) begin
            o_segment_outputs[c] <= LVL_VLCD;
         end
      end else begin
         for (int c = 0; c < SEGS; c++) begin
            o_segment_outputs[c] <= seg_level(disp_reg_ff[c], phase_ff.pol,
                                              ctrl_ff.half_bias,
                                              ctrl_ff.mode == MODE_STATIC);
         end
      end
   end

   assign o_backplane_out_0 = bp_ff[0];
   assign o_backplane_out_1 = bp_ff[1];
   assign o_backplane_out_2 = bp_ff[2];
   assign o_backplane_out_3 = bp_ff[3];

   // ==========================================================
   // checks
   logic [5:0] osc_seen_ff;
   logic [15:0] gap_ff;
   logic [15:0] gap_want;
   logic [3:0] bp_extreme;
   logic rate_seen_ff;
   logic [1:0] rate_sel_ff;
   logic rate_mixed_ff;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         osc_seen_ff <= 6'h00;
      end else if (tick) begin
         osc_seen_ff <= 6'h00;
      end else if (osc_tick) begin
         osc_seen_ff <= osc_seen_ff + 6'h01;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         gap_ff <= 16'h0000;
      end else if (tick) begin
         gap_ff <= 16'h0000;
      end else if (gap_ff != 16'hFFFF) begin
         gap_ff <= gap_ff + 16'h0001;
      end
   end

   assign gap_want = 16'({osc_limit + 9'h001, 6'h00}) - 16'h0001;

   // a rate or source change leaves one mixed period behind it
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rate_seen_ff <= 1'b0;
         rate_sel_ff <= 2'h0;
         rate_mixed_ff <= 1'b0;
      end else begin
         rate_seen_ff <= 1'b1;
         rate_sel_ff <= {i_osc_select, i_frame_rate_select};
         if (rate_seen_ff && (rate_sel_ff != {i_osc_select, i_frame_rate_select})) begin
            rate_mixed_ff <= 1'b1;
         end else if (tick) begin
            rate_mixed_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < BPS; i++) begin
         bp_extreme[i] = (bp_ff[i] == LVL_VSS) || (bp_ff[i] == LVL_VLCD);
      end
   end

   sequence s_ext_edge;
      i_osc_select && !clk_in_d_ff && i_clk_in;
   endsequence

   sequence s_sync_early;
      sync_in_d_ff && !i_sync_in && (frame_cnt_ff != 5'h00);
   endsequence

   property p_div64;
      @(posedge i_clock) disable iff (!i_nrst)
      (tick && !i_osc_select) |-> (osc_seen_ff == 6'h3F);
   endproperty
   a_div64: assert property (p_div64)
      else $error("work tick not after 64 oscillator ticks");

   property p_clk_drive;
      @(posedge i_clock) disable iff (!i_nrst)
      !i_osc_select |=> (!o_clk_oe_n && (o_clk_out == $past(div64_ff[5])));
   endproperty
   a_clk_drive: assert property (p_clk_drive)
      else $error("clock pin not driven from divider");

   property p_ext_clk;
      @(posedge i_clock) disable iff (!i_nrst)
      s_ext_edge |-> tick ##1 o_clk_oe_n;
   endproperty
   a_ext_clk: assert property (p_ext_clk)
      else $error("external clock edge not used");

   property p_frame_wrap;
      @(posedge i_clock) disable iff (!i_nrst)
      (tick && !realign && (frame_cnt_ff == 5'd23)) |=> (frame_cnt_ff == 5'h00);
   endproperty
   a_frame_wrap: assert property (p_frame_wrap)
      else $error("frame did not wrap after 24 ticks");

   property p_rate;
      @(posedge i_clock) disable iff (!i_nrst)
      (tick && !i_osc_select && !rate_mixed_ff
         && $stable({i_osc_select, i_frame_rate_select})) |-> (gap_ff == gap_want);
   endproperty
   a_rate: assert property (p_rate)
      else $error("working clock period wrong");

   property p_sync_align;
      @(posedge i_clock) disable iff (!i_nrst)
      s_sync_early |=> (frame_cnt_ff == 5'h00) ##1 !o_sync_oe_n;
   endproperty
   a_sync_align: assert property (p_sync_align)
      else $error("frame not realigned to sync");

   property p_mux4_slots;
      @(posedge i_clock) disable iff (!i_nrst)
      (ctrl_ff.disp_en && !ctrl_ff.half_bias && (ctrl_ff.mode == MODE_MUX4))
         |=> $onehot(bp_extreme);
   endproperty
   a_mux4_slots: assert property (p_mux4_slots)
      else $error("1:4 slot not unique");

   property p_mux3_mirror;
      @(posedge i_clock) disable iff (!i_nrst)
      (ctrl_ff.mode == MODE_MUX3) |=> (bp_ff[3] == bp_ff[1]);
   endproperty
   a_mux3_mirror: assert property (p_mux3_mirror)
      else $error("backplane 3 differs from 1");

   property p_mux2_pairs;
      @(posedge i_clock) disable iff (!i_nrst)
      (ctrl_ff.mode == MODE_MUX2) |=> ((bp_ff[2] == bp_ff[0]) && (bp_ff[3] == bp_ff[1]));
   endproperty
   a_mux2_pairs: assert property (p_mux2_pairs)
      else $error("1:2 backplane pairs differ");

   property p_static_all;
      @(posedge i_clock) disable iff (!i_nrst)
      (ctrl_ff.mode == MODE_STATIC) |=> ((bp_ff[1] == bp_ff[0]) && (bp_ff[2] == bp_ff[0])
                                         && (bp_ff[3] == bp_ff[0]));
   endproperty
   a_static_all: assert property (p_static_all)
      else $error("static backplanes differ");

   property p_disabled;
      @(posedge i_clock) disable iff (!i_nrst)
      !ctrl_ff.disp_en |=> (bp_ff[0] == LVL_VLCD) && (o_segment_outputs[0] == LVL_VLCD);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("outputs active while disabled");

endmodule // lcd_timing_driver
`default_nettype wire

/* File: tb/cascade_peer.sv */
/*
 cascade peer model: free clock source and sync puller.
 assumes the bench wires its outputs onto the shared pins.
*/
`default_nettype none
module cascade_peer (
   input wire logic i_clock,
   input wire logic i_pull,
   output logic o_clk,
   output logic o_sync_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] div_ff = 4'h0;
   // ==========
   // clock source
   // never stopped: a still clock would freeze the drive at dc
   always_ff @(posedge i_clock) begin
      div_ff <= div_ff + 4'h1;
   end
   assign o_clk = div_ff[3];
   assign o_sync_n = ~i_pull;
endmodule // cascade_peer
`default_nettype wire

/* File: tb/lcd_multiplex_timing_driver_bench.sv */
/*
 self-checking bench of the display timing driver.
 assumes the cascade peer model, the driver package and its header.
*/
`include "lcd_timing_cfg.svh"
`default_nettype none
module lcd_multiplex_timing_driver_bench
   import lcd_timing_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic nrst, awvalid, wvalid, bready, arvalid, rready, osc, frs, pull;
   logic awready, wready, bvalid, arready, rvalid, ck_o, ck_oe_n, sy_o, sy_oe_n, pclk, psn;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   level_t bp [4];
   level_t [79:0] seg;
   drive_mode_t md;
   logic hb, en;
   logic [3:0] ram [80];
   int cnt, ticks, base, n_errors, n_compared;
   // far end of the clock pin and the wired sync line, pulled high
   wire ck_pin = ck_oe_n ? pclk : ck_o;
   wire sy_pin = psn & (sy_oe_n | sy_o);
   always #10 clk = ~clk;
   always @(posedge pclk) ticks++;
   lcd_timing_driver dut (.i_clock(clk), .i_nrst(nrst), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_osc_select(osc), .i_frame_rate_select(frs), .i_clk_in(ck_pin), .o_clk_out(ck_o),
      .o_clk_oe_n(ck_oe_n), .i_sync_in(sy_pin), .o_sync_out(sy_o), .o_sync_oe_n(sy_oe_n),
      .o_backplane_out_0(bp[0]), .o_backplane_out_1(bp[1]), .o_backplane_out_2(bp[2]),
      .o_backplane_out_3(bp[3]), .o_segment_outputs(seg));
   cascade_peer peer (.i_clock(clk), .i_pull(pull), .o_clk(pclk), .o_sync_n(psn));
   // ==========
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw = 1'h0, w = 1'h0, b = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int t = 0; t < 200 && !b; t++) begin
         @(posedge clk);
         aw |= awready;
         w |= wready;
         awvalid <= !aw;
         wvalid <= !w;
         b = bvalid;
      end
      chk(b, 1'h1);
      chk(bresp, er);
      bready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      bit ar = 1'h0, r = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int t = 0; t < 200 && !r; t++) begin
         @(posedge clk);
         ar |= arready;
         arvalid <= !ar;
         r = rvalid;
      end
      chk(r, 1'h1);
      chk(rdata, d);
      chk(rresp, er);
      rready <= 1'h0;
      @(posedge clk);
   endtask
   // clocks between two toggles of the cascade clock output
   task automatic half(input int n);
      logic v;
      int t = 0;
      @(posedge clk);
      v = ck_o;
      while (ck_o === v) @(posedge clk);
      v = ck_o;
      while (ck_o === v) begin
         @(posedge clk);
         t++;
      end
      chk(t, n);
   endtask
   // expected level from mode, bias, frame position and column data
   function automatic level_t ex(input bit sg, input int i);
      int n = (md == MODE_STATIC) ? 1 : (md == MODE_MUX2) ? 2 : (md == MODE_MUX3) ? 3 : 4;
      int l = 24 / n;
      int s = cnt / l;
      bit p = (cnt % l) >= l / 2;
      bit sl = (md == MODE_MUX3 && i == 3) ? (s == 1) : (i % n == s);
      if (!en) return LVL_VLCD;
      if (sg && ram[i][s]) return p ? LVL_VLCD : LVL_VSS;
      if (sg && n == 1) return p ? LVL_VSS : LVL_VLCD;
      if (sg || !sl) return hb ? LVL_LO : (sg ^ p) ? LVL_HI : LVL_LO;
      return p ? LVL_VSS : LVL_VLCD;
   endfunction
   // sampled mid-tick, clear of the output lag
   task automatic tick(input bit ck);
      repeat (24) begin
         @(posedge pclk);
         repeat (8) @(posedge clk);
         cnt = (ticks - base) % 24;
         if (ck) begin
            chk(sy_oe_n, cnt >= 12);
            for (int i = 0; i < 4; i++) chk(bp[i], ex(0, i));
            for (int c = 0; c < 80; c++) chk(seg[c], ex(1, c));
         end
      end
   endtask
   // two pulls twelve ticks apart: one meets a released line
   task automatic sync_up;
      @(posedge pclk);
      repeat (2) begin
         repeat (8) @(posedge clk);
         pull <= 1'h1;
         repeat (2) @(posedge clk);
         pull <= 1'h0;
         repeat (12) @(posedge pclk);
      end
      @(posedge clk);
      base = ticks - 12;
   endtask
   task wrap_up;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========
   // sequence
   initial begin
      {nrst, awvalid, wvalid, bready, arvalid, rready, osc, pull} = 8'h0;
      frs = 1'h1;
      {awaddr, araddr, wdata} = 56'h0;
      void'($urandom(32'hDEAF));
      repeat (10) @(posedge clk);
      chk(bp[2], LVL_VLCD);
      chk(seg[79], LVL_VLCD);
      nrst <= 1'h1;
      wr(`LCD_ADDR_STATUS, 32'hF, `LCD_RESP_OKAY);
      rd(`LCD_ADDR_CTRL, 32'h0, `LCD_RESP_OKAY);
      wr(12'hFF0, 32'hF, `LCD_RESP_SLVERR);
      rd(12'hFF0, 32'h0, `LCD_RESP_SLVERR);
      chk(ck_oe_n, 1'h0);
      half(`LCD_OSC_DIV / 2 * `LCD_OSC_CYC_SLOW);
      frs <= 1'h0;
      half(`LCD_OSC_DIV / 2 * `LCD_OSC_CYC_FAST);
      osc <= 1'h1;
      for (int c = 0; c < 80; c++) begin
         ram[c] = (c == 0) ? 4'hF : 4'($urandom);
         wr(`LCD_ADDR_RAM_LO + 12'(4 * c), {28'h0, ram[c]}, `LCD_RESP_OKAY);
      end
      chk(ck_oe_n, 1'h1);
      sync_up();
      for (int k = 0; k < 9; k++) begin
         md = drive_mode_t'(k[1:0]);
         hb = k[2];
         en = (k < 8);
         wr(`LCD_ADDR_CTRL, {28'h0, en, hb, md}, `LCD_RESP_OKAY);
         tick(1'h0);
         tick(1'h1);
      end
      wrap_up();
   end
   initial begin
      #2_000_000;
      n_errors++;
      wrap_up();
   end
endmodule // lcd_multiplex_timing_driver_bench
`default_nettype wire
